/* verilog/queue_index_unit.sv */
// Circular queue index unit: two command queues and two event queues,
// APB register access, device-side step ports.
// Assumes APB master on pclk, step requests from pclk logic and a
// secure-side strap pin from outside the clock domain.
// Pointers stay writable while a queue is disabled; only steps are gated.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

`include "qi_consts.svh"

// How it works
// - Queues hold two to the n entries
// - Fill and drain pointers are 20 bits
// - Lap flag just above index, rest ignored
// - Equal slots, equal flags means empty
// - Equal slots, differing flags means full
// - Pointers name next write and read slots
// - Owner toggles lap flag on wrap
// - Indexes only increment or wrap
// - Command queue: software fills, device drains
// - Event queues: device fills, software drains
// - Inconsistent pointers stop device stepping
// - All entries may be valid at once
// - Software picks size up to maximum
// - One command queue per security state, in order
// - Secure event queue only when secure present
// - Output queues appended strictly sequentially
module queue_index_unit
   import qi_pkg::*;
(
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [7:0]                      paddr,
   input  wire logic [31:0]                     pwdata,
   output var  logic [31:0]                     prdata,
   output var  logic                            pready,
   output var  logic                            pslverr,
   input  wire logic                            secure_side_present,
   input  wire logic [`QI_NQ-1:0]               step_req,
   output var  logic [`QI_NQ-1:0]               step_ack,
   output var  logic [`QI_NQ-1:0][`QI_IDX_W-1:0] step_slot,
   output var  logic [`QI_NQ-1:0]               q_empty,
   output var  logic [`QI_NQ-1:0]               q_full
);

   logic                              sec_meta_q;
   logic                              sec_q;
   qctl_t [`QI_NQ-1:0]                ctl_q;
   qctl_t [`QI_NQ-1:0]                ctl_d;
   qctl_t [`QI_NQ-1:0]                ctl_eff;
   logic [31:0]                       prdata_d;
   logic                              pready_d;
   logic                              pslverr_d;
   logic [`QI_NQ-1:0]                 step_ack_d;
   logic [`QI_NQ-1:0][`QI_IDX_W-1:0]  step_slot_d;
   logic [`QI_NQ-1:0]                 wr_fill;
   logic [`QI_NQ-1:0]                 wr_drain;
   logic [`QI_NQ-1:0]                 empty_v;
   logic [`QI_NQ-1:0]                 full_v;
   logic [`QI_NQ-1:0][`QI_PTR_W-1:0]  fill_v;
   logic [`QI_NQ-1:0][`QI_PTR_W-1:0]  drain_v;
   qstat_t [`QI_NQ-1:0]               stat_v;
   logic [`QI_NQ-1:0]                 go_v;
   logic [`QI_NQ-1:0][`QI_IDX_W-1:0]  slot_v;
   logic                              take;
   logic                              unmapped;
   logic [1:0]                        qsel;
   logic [3:0]                        rsel;
   logic [`QI_LOG2_W-1:0]             log2_w;

   // ************************************************************
   // Strap synchroniser
   // ************************************************************

   // The strap is a pin; only the second flop is ever read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_meta_q <= 1'b0;
         sec_q      <= 1'b0;
      end else begin
         sec_meta_q <= secure_side_present;
         sec_q      <= sec_meta_q;
      end
   end

   // ************************************************************
   // Queue pointer pairs
   // ************************************************************

   // Secure queues stay dormant until the strap says the side exists
   always_comb begin
      for (int i = 0; i < `QI_NQ; i++) begin
         ctl_eff[i]    = ctl_q[i];
         ctl_eff[i].en = ctl_q[i].en && (i[`QI_Q_SEC_BIT] == 1'b0 || sec_q);
      end
      ctl_eff[`QI_Q_EVT_S].en = ctl_q[`QI_Q_EVT_S].en && sec_q;
   end

   // Lower-numbered half consumes commands, upper half produces events
   for (genvar g = 0; g < `QI_NQ; g++) begin : g_q
      queue_ptr_pair #(
         .DEV_FILL_POINTER (g >= `QI_Q_EVT_NS)
      ) u_pair (
         .clk       (pclk),
         .rst_n     (presetn),
         .ctl       (ctl_eff[g]),
         .wr_fill   (wr_fill[g]),
         .wr_drain  (wr_drain[g]),
         .wdata     (pwdata[`QI_PTR_W-1:0]),
         .step_req  (step_req[g]),
         .fill_q    (fill_v[g]),
         .drain_q   (drain_v[g]),
         .stat      (stat_v[g]),
         .step_go   (go_v[g]),
         .step_slot (slot_v[g])
      );
   end

   // ************************************************************
   // APB slave
   // ************************************************************

   // One wait state: pready rises in the second access cycle, so
   // prdata can come from a flop without a combinational path
   always_comb begin
      take      = psel && penable && pready;
      qsel      = paddr[`QI_ADDR_Q];
      rsel      = paddr[`QI_ADDR_REG];
      unmapped  = (paddr[`QI_ADDR_ALIGN] != 2'h0) || (paddr > `QI_OFF_LAST);
      log2_w    = pwdata[`QI_CTRL_LOG2];
      // Sizes above the supported maximum clamp to it
      if (log2_w > `QI_MAX_LOG2) begin
         log2_w = `QI_MAX_LOG2;
      end
      ctl_d     = ctl_q;
      wr_fill   = '0;
      wr_drain  = '0;
      if (take && pwrite && !unmapped && paddr < `QI_OFF_ID) begin
         case (rsel)
            `QI_OFF_FILL: begin
               wr_fill[qsel] = 1'b1;
            end
            `QI_OFF_DRAIN: begin
               wr_drain[qsel] = 1'b1;
            end
            `QI_OFF_CTRL: begin
               ctl_d[qsel].en   = pwdata[`QI_CTRL_EN];
               ctl_d[qsel].log2 = log2_w;
            end
            default: begin
               ctl_d = ctl_q;
            end
         endcase
      end
      pready_d  = psel && penable && !pready;
      pslverr_d = pready_d && unmapped;
      prdata_d  = `QI_WORD_RST;
      if (pready_d && !pwrite && !unmapped) begin
         if (paddr == `QI_OFF_ID) begin
            prdata_d[`QI_ID_LOG2] = `QI_MAX_LOG2;
            prdata_d[`QI_ID_SEC]  = sec_q;
         end else begin
            case (rsel)
               `QI_OFF_FILL: begin
                  prdata_d[`QI_PTR_W-1:0] = fill_v[qsel];
               end
               `QI_OFF_DRAIN: begin
                  prdata_d[`QI_PTR_W-1:0] = drain_v[qsel];
               end
               `QI_OFF_CTRL: begin
                  prdata_d[`QI_CTRL_EN]   = ctl_q[qsel].en;
                  prdata_d[`QI_CTRL_LOG2] = ctl_q[qsel].log2;
               end
               default: begin
                  prdata_d[`QI_STAT_EMPTY] = stat_v[qsel].empty;
                  prdata_d[`QI_STAT_FULL]  = stat_v[qsel].full;
                  prdata_d[`QI_STAT_BAD]   = stat_v[qsel].bad;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Step answers and status outputs
   // ************************************************************

   // Slot is held between steps so the user may sample it late
   always_comb begin
      step_ack_d  = go_v;
      step_slot_d = step_slot;
      for (int i = 0; i < `QI_NQ; i++) begin
         empty_v[i] = stat_v[i].empty;
         full_v[i]  = stat_v[i].full;
         if (go_v[i]) begin
            step_slot_d[i] = slot_v[i];
         end
      end
   end

   // All top outputs come from these flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `QI_NQ; i++) begin
            ctl_q[i].en   <= 1'b0;
            ctl_q[i].log2 <= `QI_LOG2_RST;
         end
         prdata    <= `QI_WORD_RST;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         step_ack  <= '0;
         step_slot <= '0;
         q_empty   <= '0;
         q_full    <= '0;
      end else begin
         ctl_q     <= ctl_d;
         prdata    <= prdata_d;
         pready    <= pready_d;
         pslverr   <= pslverr_d;
         step_ack  <= step_ack_d;
         step_slot <= step_slot_d;
         for (int i = 0; i < `QI_NQ; i++) begin
            q_empty[i] <= stat_v[i].empty;
            q_full[i]  <= stat_v[i].full;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************

   sequence s_access_wait;
      psel && penable && !pready;
   endsequence

   apb_one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_access_wait |=> pready ##1 !pready)
      else $error("pready not a single pulse after one wait");
   ctrl_on_take_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable && pready && pwrite) |=> $stable(ctl_q))
      else $error("control changed outside an APB write");
   ack_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
      go_v[`QI_Q_CMD_NS] |=> step_ack[`QI_Q_CMD_NS]
                             && step_slot[`QI_Q_CMD_NS] == $past(slot_v[`QI_Q_CMD_NS]))
      else $error("ack or slot does not follow the step");
   sec_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !sec_q |=> !step_ack[`QI_Q_EVT_S] && !step_ack[`QI_Q_CMD_S])
      else $error("secure queue stepped without secure side");
   cmd_order_a: assert property (@(posedge pclk) disable iff (!presetn)
      (step_ack[`QI_Q_CMD_NS] && $past(step_ack[`QI_Q_CMD_NS]) && $past(ctl_q[0].en, 2)
       && $stable(ctl_q[0]) && !$past(wr_drain[0], 2))
      |-> step_slot[0] == (($past(step_slot[0]) + `QI_IDX_W'(1))
                           & ((`QI_IDX_W'(1) << ctl_q[0].log2) - `QI_IDX_W'(1))))
      else $error("commands not consumed in queue order");
   size_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 (ctl_q[0].log2 <= `QI_MAX_LOG2 && ctl_q[2].log2 <= `QI_MAX_LOG2))
      else $error("queue size above supported maximum");

   // Registered outputs trail the live state by one cycle
   sequence s_evt_two_acks;
      step_ack[`QI_Q_EVT_NS] && $stable(ctl_q[`QI_Q_EVT_NS])
      ##1 (step_ack[`QI_Q_EVT_NS] && $stable(ctl_q[`QI_Q_EVT_NS]));
   endsequence

   flags_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> q_empty == $past(empty_v) && q_full == $past(full_v))
      else $error("empty or full output does not follow the pointers");
   strap_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> sec_q == $past(sec_meta_q))
      else $error("strap not passed through the second flop");

   // Step answers
   evt_append_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_evt_two_acks |-> step_slot[`QI_Q_EVT_NS] == (($past(step_slot[`QI_Q_EVT_NS])
         + `QI_IDX_W'(1)) & ((`QI_IDX_W'(1) << ctl_q[`QI_Q_EVT_NS].log2) - `QI_IDX_W'(1))))
      else $error("event slots not appended one after another");
   slot_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !step_ack[`QI_Q_CMD_NS] |-> $stable(step_slot[`QI_Q_CMD_NS]))
      else $error("slot changed without a step");
   ack_needs_en_a: assert property (@(posedge pclk) disable iff (!presetn)
      step_ack[`QI_Q_CMD_NS] |-> $past(ctl_q[`QI_Q_CMD_NS].en))
      else $error("step taken on a disabled queue");

   // Bus answer shape
   err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error reported outside a ready cycle");
   rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == `QI_WORD_RST)
      else $error("read data not zero outside a ready cycle");
   max_size_a: assert property (@(posedge pclk) disable iff (!presetn)
      (pready && !pwrite && paddr == `QI_OFF_ID) |-> prdata[`QI_ID_LOG2] == `QI_MAX_LOG2)
      else $error("maximum size not reported");

endmodule

`default_nettype wire

/* include/qi_consts.svh */
// Named constants for the circular queue index unit: widths, offsets,
// field positions, reset values and queue numbering.
// Assumes inclusion by bare name from the package and the design files.
`ifndef QI_CONSTS_SVH
`define QI_CONSTS_SVH

// Pointer and index widths
`define QI_PTR_W        20
`define QI_IDX_W        19
`define QI_LOG2_W       5
`define QI_MAX_LOG2     5'h13
`define QI_NQ           4

// Queue numbering: bit 0 set means the secure side
`define QI_Q_CMD_NS     0
`define QI_Q_CMD_S      1
`define QI_Q_EVT_NS     2
`define QI_Q_EVT_S      3

// Register window: queue number in paddr[5:4], register in paddr[3:0]
`define QI_OFF_FILL     4'h0
`define QI_OFF_DRAIN    4'h4
`define QI_OFF_CTRL     4'h8
`define QI_OFF_STAT     4'hc
`define QI_OFF_ID       8'h40
`define QI_OFF_LAST     8'h40
`define QI_ADDR_Q       5:4
`define QI_ADDR_REG     3:0
`define QI_ADDR_ALIGN   1:0
`define QI_Q_SEC_BIT    0

// Field positions
`define QI_CTRL_EN      0
`define QI_CTRL_LOG2    12:8
`define QI_STAT_EMPTY   0
`define QI_STAT_FULL    1
`define QI_STAT_BAD     2
`define QI_ID_LOG2      4:0
`define QI_ID_SEC       8

// Reset values
`define QI_PTR_RST      20'h00000
`define QI_LOG2_RST     5'h00
`define QI_WORD_RST     32'h0000_0000

`endif

/* include/qi_pkg.sv */
// Types shared by the queue index unit and its pointer-pair leaf.
// Assumes qi_consts.svh is on the include path.
`include "qi_consts.svh"

package qi_pkg;

   // Software control of one queue
   typedef struct packed {
      logic                  en;
      logic [`QI_LOG2_W-1:0] log2;
   } qctl_t;

   // Observed state of one queue
   typedef struct packed {
      logic empty;
      logic full;
      logic bad;
   } qstat_t;

endpackage

/* verilog/queue_ptr_pair.sv */
// One queue's fill and drain pointers with lap-flag empty/full logic.
// Assumes a single clock; software writes and device steps come from the
// same domain as clk.
`timescale 1ns/1ns
`default_nettype none

`include "qi_consts.svh"

module queue_ptr_pair
   import qi_pkg::*;
#(
   parameter bit DEV_FILL_POINTER = 1'b0
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire qctl_t                 ctl,
   input  wire logic                  wr_fill,
   input  wire logic                  wr_drain,
   input  wire logic [`QI_PTR_W-1:0]  wdata,
   input  wire logic                  step_req,
   output var  logic [`QI_PTR_W-1:0]  fill_q,
   output var  logic [`QI_PTR_W-1:0]  drain_q,
   output var  qstat_t                stat,
   output var  logic                  step_go,
   output var  logic [`QI_IDX_W-1:0]  step_slot
);

   logic [`QI_PTR_W-1:0] idx_mask;
   logic [`QI_PTR_W-1:0] fld_mask;
   logic [`QI_PTR_W-1:0] wrap_bit;
   logic [`QI_PTR_W-1:0] f_idx;
   logic [`QI_PTR_W-1:0] d_idx;
   logic                 f_wr;
   logic                 d_wr;
   logic [`QI_PTR_W-1:0] own;
   logic [`QI_PTR_W-1:0] own_next;
   logic                 own_wr;
   logic [`QI_PTR_W-1:0] fill_d;
   logic [`QI_PTR_W-1:0] drain_d;
   logic [`QI_PTR_W-1:0] cnt;

   // ************************************************************
   // Lap-flag decode and the device step
   // ************************************************************

   // Lap flag sits just above the index; bits above it are ignored
   always_comb begin
      idx_mask  = (`QI_PTR_W'(1) << ctl.log2) - `QI_PTR_W'(1);
      fld_mask  = {idx_mask[`QI_PTR_W-2:0], 1'b1};
      wrap_bit  = `QI_PTR_W'(1) << ctl.log2;
      f_idx     = fill_q & idx_mask;
      d_idx     = drain_q & idx_mask;
      f_wr      = |(fill_q & wrap_bit);
      d_wr      = |(drain_q & wrap_bit);
      stat.empty = (f_idx == d_idx) && (f_wr == d_wr);
      stat.full  = (f_idx == d_idx) && (f_wr != d_wr);
      // Inconsistent pair: producer ahead with lap flags apart, or behind
      stat.bad   = (f_wr == d_wr) ? (f_idx < d_idx) : (f_idx > d_idx);
      own       = DEV_FILL_POINTER ? fill_q : drain_q;
      own_wr    = DEV_FILL_POINTER ? wr_fill : wr_drain;
      // A step in the cycle of a software write to the same pointer is
      // refused, not merged, so the write never loses a step silently
      step_go   = step_req && ctl.en && !own_wr && !stat.bad
                  && (DEV_FILL_POINTER ? !stat.full : !stat.empty);
      step_slot = own[`QI_IDX_W-1:0] & idx_mask[`QI_IDX_W-1:0];
      // Carry out of the index lands in the lap flag: wrap toggles it
      own_next  = (own & ~fld_mask) | ((own + `QI_PTR_W'(1)) & fld_mask);
      fill_d    = fill_q;
      drain_d   = drain_q;
      if (wr_fill) begin
         fill_d = wdata;
      end else if (DEV_FILL_POINTER && step_go) begin
         fill_d = own_next;
      end
      if (wr_drain) begin
         drain_d = wdata;
      end else if (!DEV_FILL_POINTER && step_go) begin
         drain_d = own_next;
      end
      cnt = (fill_q - drain_q) & fld_mask;
   end

   // Pointer registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fill_q  <= `QI_PTR_RST;
         drain_q <= `QI_PTR_RST;
      end else begin
         fill_q  <= fill_d;
         drain_q <= drain_d;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************

   sequence s_two_steps;
      step_go ##1 (step_go && !$past(own_wr));
   endsequence

   no_empty_take_a: assert property (@(posedge clk) disable iff (!rst_n)
      (step_go && !DEV_FILL_POINTER) |-> !stat.empty)
      else $error("consumer stepped an empty queue");
   no_full_put_a: assert property (@(posedge clk) disable iff (!rst_n)
      (step_go && DEV_FILL_POINTER) |-> !stat.full)
      else $error("producer stepped a full queue");
   all_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
      stat.full |-> (cnt == wrap_bit))
      else $error("full queue does not hold every entry");
   wrap_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (step_go && step_slot == idx_mask[`QI_IDX_W-1:0] && $stable(ctl.log2))
      |=> ((DEV_FILL_POINTER ? fill_q : drain_q) & idx_mask) == '0
          && (|((DEV_FILL_POINTER ? fill_q : drain_q) & wrap_bit)) != $past(|(own & wrap_bit)))
      else $error("wrap did not reset index and toggle lap flag");
   forward_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!own_wr && !step_go) |=> $stable(DEV_FILL_POINTER ? fill_q : drain_q))
      else $error("device pointer moved without a step");
   seq_append_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_two_steps |-> step_slot == (($past(step_slot) + `QI_IDX_W'(1))
                                    & idx_mask[`QI_IDX_W-1:0]))
      else $error("slots not taken one after another");
   bad_blocks_a: assert property (@(posedge clk) disable iff (!rst_n)
      stat.bad |-> !step_go)
      else $error("step taken with inconsistent pointers");

endmodule

`default_nettype wire

/* tb/step_engine.sv */
// Model of the engine that steps the queues at the device-side ports.
// Assumes pclk domain; the bench sets go per queue, this holds step_req.
`timescale 1ns/1ns
`default_nettype none

`include "qi_consts.svh"

module step_engine
   import qi_pkg::*;
(
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic [`QI_NQ-1:0]                go,
   input  wire logic [`QI_NQ-1:0]                step_ack,
   input  wire logic [`QI_NQ-1:0][`QI_IDX_W-1:0] step_slot,
   output var  logic [`QI_NQ-1:0]                step_req
);
   // ****************************************
   // Request level and slot log
   // ****************************************
   logic [`QI_IDX_W-1:0] seen [`QI_NQ][$];

   // Level request held until the bench drops go
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_req <= '0;
      end else begin
         step_req <= go;
      end
   end

   // Every taken slot is logged so order can be judged
   always @(posedge pclk) begin
      for (int i = 0; i < `QI_NQ; i++) begin
         if (step_ack[i] === 1'b1) begin
            seen[i].push_back(step_slot[i]);
         end
      end
   end
endmodule

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the queue index unit.
// Assumes the design files, the package and the step engine model.
`timescale 1ns/1ns
`default_nettype none

`include "qi_consts.svh"

module tb
   import qi_pkg::*;
;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic                             pclk;
   logic                             presetn;
   logic                             psel;
   logic                             penable;
   logic                             pwrite;
   logic [7:0]                       paddr;
   logic [31:0]                      pwdata;
   logic [31:0]                      prdata;
   logic                             pready;
   logic                             pslverr;
   logic                             strap;
   logic [`QI_NQ-1:0]                go;
   logic [`QI_NQ-1:0]                step_req;
   logic [`QI_NQ-1:0]                step_ack;
   logic [`QI_NQ-1:0][`QI_IDX_W-1:0] step_slot;
   logic [`QI_NQ-1:0]                q_empty;
   logic [`QI_NQ-1:0]                q_full;
   int                               err_total = 0;
   int                               n_checks = 0;
   logic [31:0]                      rd;
   logic                             er;

   queue_index_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .secure_side_present(strap), .step_req(step_req),
      .step_ack(step_ack), .step_slot(step_slot), .q_empty(q_empty), .q_full(q_full));

   step_engine i_eng (.pclk(pclk), .presetn(presetn), .go(go), .step_ack(step_ack),
      .step_slot(step_slot), .step_req(step_req));

   // Clock at 50 ns period
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One APB transfer; waits on pready, bounded by the watchdog
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, er);
      chk({31'h0, er}, 32'h0);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, rd, er);
      chk(rd, exp);
   endtask

   // Program pointers, then enable
   task automatic setup_q(input int q, input logic [19:0] f, input logic [19:0] dr,
                          input logic [31:0] ctl);
      wr(8'(16 * q) + `QI_OFF_FILL, {12'h0, f});
      wr(8'(16 * q) + `QI_OFF_DRAIN, {12'h0, dr});
      wr(8'(16 * q) + `QI_OFF_CTRL, ctl);
   endtask

   // Hold the request long enough to hit the blocking point, then judge slots
   task automatic run_chk(input int q, input int start, input int cnt, input int sz);
      i_eng.seen[q].delete();
      go[q] <= 1'b1;
      repeat (12) @(posedge pclk);
      go[q] <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'(i_eng.seen[q].size()), 32'(cnt));
      for (int k = 0; k < cnt && k < i_eng.seen[q].size(); k++) begin
         chk({13'h0, i_eng.seen[q][k]}, 32'((start + k) % sz));
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      rd_chk(`QI_OFF_FILL, 32'h0);
      rd_chk(`QI_OFF_STAT, 32'h1);
      rd_chk(8'h30 + `QI_OFF_CTRL, 32'h0);
      rd_chk(`QI_OFF_ID, 32'h0000_0013);
      chk({28'h0, q_empty}, 32'hf);
   endtask

   task automatic t_map();
      apb(1'b0, 8'h44, 32'h0, rd, er);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 8'h01, 32'h1, rd, er);
      chk({31'h0, er}, 32'h1);
      wr(`QI_OFF_ID, 32'hffff_ffff);
      rd_chk(`QI_OFF_ID, 32'h0000_0013);
      wr(8'h10 + `QI_OFF_CTRL, 32'h0000_1f00);
      rd_chk(8'h10 + `QI_OFF_CTRL, 32'h0000_1300);
      wr(8'h10 + `QI_OFF_CTRL, 32'h0);
   endtask

   // Upper bits of fill are junk and must not count
   task automatic t_cmd();
      setup_q(0, 20'hfff03, 20'h0, 32'h0000_0201);
      run_chk(0, 0, 3, 4);
      rd_chk(`QI_OFF_DRAIN, 32'h0000_0003);
      chk({31'h0, q_empty[0]}, 32'h1);
      wr(`QI_OFF_FILL, 32'h0000_0005);
      run_chk(0, 3, 2, 4);
      rd_chk(`QI_OFF_DRAIN, 32'h0000_0005);
   endtask

   // Device fills every slot, software frees two
   task automatic t_evt();
      setup_q(2, 20'h0, 20'h0, 32'h0000_0201);
      run_chk(2, 0, 4, 4);
      rd_chk(8'h20 + `QI_OFF_FILL, 32'h0000_0004);
      rd_chk(8'h20 + `QI_OFF_STAT, 32'h0000_0002);
      chk({31'h0, q_full[2]}, 32'h1);
      wr(8'h20 + `QI_OFF_DRAIN, 32'h0000_0002);
      run_chk(2, 0, 2, 4);
      rd_chk(8'h20 + `QI_OFF_FILL, 32'h0000_0006);
   endtask

   // Fill above drain with differing flags on purpose
   task automatic t_bad();
      wr(8'h20 + `QI_OFF_FILL, 32'h0000_0002);
      wr(8'h20 + `QI_OFF_DRAIN, 32'h0000_0005);
      rd_chk(8'h20 + `QI_OFF_STAT, 32'h0000_0004);
      run_chk(2, 0, 0, 4);
   endtask

   // Secure event queue acts only with the strap high
   task automatic t_sec();
      setup_q(3, 20'h0, 20'h0, 32'h0000_0101);
      setup_q(1, 20'h1, 20'h0, 32'h0000_0101);
      run_chk(3, 0, 0, 2);
      run_chk(1, 0, 0, 2);
      strap <= 1'b1;
      repeat (3) @(posedge pclk);
      rd_chk(`QI_OFF_ID, 32'h0000_0113);
      run_chk(3, 0, 2, 2);
      chk({31'h0, q_full[3]}, 32'h1);
      run_chk(1, 0, 1, 2);
      chk({31'h0, q_empty[1]}, 32'h1);
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      strap   = 1'b0;
      go      = 4'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_map();
      t_cmd();
      t_evt();
      t_bad();
      t_sec();
      final_report();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge pclk);
      err_total++;
      final_report();
   end
endmodule

`default_nettype wire
